// ==== bench/dcd_host.sv ====
`timescale 1ns/100ps
// ==========================================================
// Host model: Avalon-MM master doing one transfer at a time
module dcd_host (
  // Clock
  input wire logic clk,
  // Avalon-MM master side
  output logic [3:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end

  // Request held until waitrequest is seen low; once released, read and write drop low while address and data show inverted values
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask
endmodule // dcd_host

// ==== bench/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  import dcd_pkg::*;
  typedef struct {logic [4:0] ctrl; logic [7:0] code; int idx; int ch; int ir;} dcd_row_t;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic [3:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [ACT_W-1:0] action_pulse, seen;
  logic cmd_chainable, cmd_irq_end, rx_masked, test_open, test_clear, seen_clr;
  int miscompares = 0;
  int cmp_count = 0;
  // ==========================================================
  // Rows: control bits, code, pulse index (-1 none), chainable, irq (2 = not checked)
  // clear issued ahead of the transmit codes
  dcd_row_t rows[] = '{
    '{5'h00, 8'hC1, A_DEFAULT, 0, 0}, '{5'h01, 8'hC2, A_CLEAR, 1, 0},
    '{5'h01, 8'hC3, A_CLEAR, 1, 0}, '{5'h03, 8'hC4, A_TX_CRC, 1, 0},
    '{5'h03, 8'hC5, A_TX_NOCRC, 1, 0}, '{5'h0B, 8'hC6, A_TX_REQA, 1, 0},
    '{5'h0B, 8'hC7, A_TX_WUPA, 2, 0}, '{5'h01, 8'hC8, A_FIELD_INIT, 1, 2},
    '{5'h01, 8'hC9, A_FIELD_RESP, 1, 1}, '{5'h01, 8'hCA, A_FIELD_RESP0, 1, 1},
    '{5'h10, 8'hCB, A_GO_NORMAL, 1, 0}, '{5'h00, 8'hCC, A_PRESET, 1, 0},
    '{5'h05, 8'hD0, A_MASK_RX, 1, 0}, '{5'h05, 8'hD1, A_UNMASK_RX, 1, 0},
    '{5'h01, 8'hD3, A_MEAS_AMPL, 0, 1}, '{5'h05, 8'hD4, A_SQUELCH, 0, 0},
    '{5'h01, 8'hD5, A_RESET_GAIN, 0, 0}, '{5'h01, 8'hD6, A_ADJ_REG, 0, 1},
    '{5'h01, 8'hD7, A_CAL_MOD, 0, 1}, '{5'h01, 8'hD8, A_CAL_ANT, 0, 1},
    '{5'h01, 8'hD9, A_MEAS_PHASE, 2, 1}, '{5'h01, 8'hDA, A_CLEAR_RSSI, 1, 0},
    '{5'h00, 8'hDD, A_CAL_CAP, 0, 1}, '{5'h00, 8'hDE, A_MEAS_CAP, 0, 1},
    '{5'h01, 8'hDF, A_MEAS_SUPPLY, 0, 1}, '{5'h1E, 8'hC2, -1, 2, 2},
    '{5'h1D, 8'hC4, -1, 2, 2}, '{5'h17, 8'hC6, -1, 2, 2}, '{5'h1B, 8'hD0, -1, 2, 2},
    '{5'h1B, 8'hD4, -1, 2, 2}, '{5'h0F, 8'hCB, -1, 2, 2}, '{5'h1E, 8'hD3, -1, 2, 2},
    '{5'h1E, 8'hDF, -1, 2, 2}, '{5'h1E, 8'hC8, -1, 2, 2}, '{5'h1F, 8'hD2, -1, 2, 2},
    '{5'h1F, 8'hDC, -1, 2, 2}, '{5'h1F, 8'hE0, -1, 2, 2}, '{5'h1F, 8'hFF, -1, 2, 2}};

  always #50 clk = ~clk;

  dcd_decoder dut (.clk(clk), .reset(reset), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .action_pulse(action_pulse), .cmd_chainable(cmd_chainable), .cmd_irq_end(cmd_irq_end),
    .rx_masked(rx_masked), .test_open(test_open), .test_clear(test_clear));

  dcd_host host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  // ==========================================================
  // Shared tasks
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [3:0] a);
    host.xfer(1'b0, a, 32'h0, q);
  endtask

  // Pulses are gathered over three edges, so no one-cycle strobe slips by
  task automatic cmd(input logic [7:0] c);
    seen = '0;
    seen_clr = 1'b0;
    wr(REG_CMD, {24'h0, c});
    repeat (3) begin
      @(posedge clk);
      seen = seen | action_pulse;
      seen_clr = seen_clr | test_clear;
    end
    @(negedge clk);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk("out_after_reset", {action_pulse, cmd_chainable, cmd_irq_end, rx_masked, test_open},
        '0);
    rd(REG_CTRL);
    chk("ctrl_reset", q[4:0], CTRL_RESET);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(REG_CTRL, {27'h0, rows[i].ctrl});
      cmd(rows[i].code);
      chk("action", seen, rows[i].idx < 0 ? 0 : 1 << rows[i].idx);
      rd(REG_CMD);
      chk("accepted", q[8], rows[i].idx >= 0);
      if (rows[i].idx >= 0 && rows[i].ch < 2) chk("chainable", cmd_chainable, rows[i].ch);
      if (rows[i].idx >= 0 && rows[i].ir < 2) chk("irq_end", cmd_irq_end, rows[i].ir);
      $display("test code %h done", rows[i].code);
    end
    wr(REG_CTRL, 32'h7);
    cmd(8'hD0);
    chk("masked", rx_masked, 1);
    rd(REG_STATUS);
    chk("status", q[3:0], 4'h5);
    cmd(8'hC1);
    chk("masked_default", rx_masked, 0);
    rd(REG_CTRL);
    chk("ctrl_kept", q[4:0], 5'h07);
    cmd(8'hD0);
    // Enable low holds a pending unmask off
    @(posedge clk);
    clk_en <= 1'b0;
    fork
      wr(REG_CMD, 32'hD1);
      begin
        repeat (4) @(posedge clk);
        chk("frozen", {avs_waitrequest, rx_masked}, 2'b11);
        clk_en <= 1'b1;
      end
    join
    @(negedge clk);
    chk("unmasked", rx_masked, 0);
    $display("test mask done");
    wr(REG_CTRL, 32'h0);
    cmd(8'hFC);
    chk("test_open", test_open, 1);
    chk("fc_pulse", seen, 0);
    cmd(8'hFA);
    chk("test_clear", seen_clr, 1);
    cmd(8'hCC);
    cmd(8'hFA);
    chk("fa_unchained", seen_clr, 0);
    $display("test access done");
    wr(4'h2, 32'h1F);
    rd(4'h2);
    chk("unmapped", q, 0);
    rd(REG_CTRL);
    chk("ctrl_untouched", q[4:0], 5'h00);
    $display("test unmapped done");
    // second reset mid-run brings power-up defaults
    wr(REG_CTRL, 32'h5);
    cmd(8'hD0);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk("masked_reset", rx_masked, 0);
    rd(REG_CTRL);
    chk("ctrl_reset2", q[4:0], CTRL_RESET);
    $display("test second reset done");
    final_report();
  end
endmodule // testbench

// ==== hdl/dcd_decoder.sv ====
`timescale 1ns/100ps
// Functional notes
// - C1 restores defaults in any mode; not chainable, no end interrupt
// - C2/C3 stop activity and clear FIFO when chip on; chainable
// - C4 transmit with CRC needs chip on and transmitter on
// - C5 transmit without CRC needs chip on and transmitter on
// - C6/C7 REQA/WUPA need 14443A mode, chip on, transmitter on
// - C8 initial collision avoidance then field on; needs chip on
// - C9/CA response collision avoidance then field on; end interrupt
// - CB leaves bit rate detection mode; accepted only in that mode
// - CC analog preset accepted in all modes, chainable
// - D0 masks received data; chip on and receiver on
// - D1 unmasks received data, overriding mask timer
// - D3 measures amplitude; end interrupt, not chainable
// - D4 squelch needs chip and receiver on; not chainable
// - D5 reloads manual gain; not chainable
// - D6 adjusts regulators; end interrupt; chip on
// - D7 calibrates modulation depth; end interrupt
// - D8 tunes antenna capacitors; end interrupt
// - D9 measures phase; end interrupt
// - DA clears RSSI, chainable, chip on
// - DD/DE capacitive sensor calibrate/measure; end interrupt
// - DF measures supply; chip on; end interrupt
// - FC opens test access; FA clears test regs only right after FC
// - Each command demands listed control bits before acceptance
// - Set-default leaves control register untouched
module dcd_decoder
  import dcd_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Action pulses and status
  output logic [dcd_pkg::ACT_W-1:0] action_pulse,
  output logic cmd_chainable,
  output logic cmd_irq_end,
  output logic rx_masked,
  output logic test_open,
  output logic test_clear
);
  // ==========================================================
  // State
  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_DONE = 2'b10
  } dcd_bus_t;

  typedef struct packed {
    dcd_bus_t bus;
    logic [31:0] rdata;
    logic [4:0] ctrl;
    logic [7:0] last_code;
    logic last_ok;
    logic [ACT_W-1:0] act;
    logic chain;
    logic irq_end;
    logic masked;
    logic strobe;
    logic [7:0] code;
  } dcd_state_t;

  dcd_state_t st, next_st;
  dcd_attr_t attr;
  logic tg_open, tg_clear;

  function automatic logic accepted(input dcd_attr_t a, input logic [4:0] c);
    accepted = a.valid && (!a.need_chip || c[CTRL_CHIP_ON]) &&
               (!a.need_tx || c[CTRL_TX_ON]) && (!a.need_rx || c[CTRL_RX_ON]) &&
               (!a.need_14a || c[CTRL_MODE_14A]) &&
               (!a.need_detect || c[CTRL_DETECT]);
  endfunction

  dcd_table u_table (
    .code(st.code),
    .attr(attr)
  );

  dcd_test_gate u_test (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .cmd_strobe(st.strobe),
    .cmd_code(st.code),
    .soft_default(st.act[A_DEFAULT]),
    .test_open(tg_open),
    .test_clear(tg_clear)
  );

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.act = '0;
    next_st.strobe = 1'b0;
    // Bus: one wait cycle per access so read data comes from a flop
    case (st.bus)
      S_IDLE: begin
        if (avs_write) begin
          next_st.bus = S_DONE;
          if (avs_address == REG_CTRL) begin
            next_st.ctrl = avs_writedata[4:0];
          end else if (avs_address == REG_CMD) begin
            next_st.strobe = 1'b1;
            next_st.code = avs_writedata[7:0];
          end
        end else if (avs_read) begin
          next_st.bus = S_DONE;
          case (avs_address)
            REG_CTRL: next_st.rdata = {27'h0000000, st.ctrl};
            REG_CMD: next_st.rdata = {23'h000000, st.last_ok, st.last_code};
            REG_STATUS: next_st.rdata = {28'h0000000, tg_open, st.masked,
                                         st.irq_end, st.chain};
            REG_ACTION: next_st.rdata = {8'h00, st.act};
            default: next_st.rdata = 32'h00000000;
          endcase
        end
      end
      S_DONE: next_st.bus = S_IDLE;
      default: next_st.bus = S_IDLE;
    endcase
    // Command execute, one cycle after the write
    if (st.strobe) begin
      next_st.last_code = st.code;
      next_st.last_ok = accepted(attr, st.ctrl);
      if (accepted(attr, st.ctrl)) begin
        next_st.act[attr.action] = 1'b1;
        next_st.chain = attr.chainable;
        next_st.irq_end = attr.irq_end;
        if (attr.action == 5'(A_MASK_RX)) begin
          next_st.masked = 1'b1;
        end
        if (attr.action == 5'(A_UNMASK_RX)) begin
          next_st.masked = 1'b0;
        end
        if (attr.action == 5'(A_GO_NORMAL)) begin
          next_st.ctrl[CTRL_DETECT] = 1'b0;
        end
        if (attr.action == 5'(A_DEFAULT)) begin
          next_st.masked = 1'b0;
          next_st.chain = 1'b0;
          next_st.irq_end = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '{bus: S_IDLE, ctrl: CTRL_RESET, default: '0};
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  // One-hot idle bit, so the pin comes straight from a flop
  assign avs_waitrequest = st.bus[0];
  assign avs_readdata = st.rdata;
  assign action_pulse = st.act;
  assign cmd_chainable = st.chain;
  assign cmd_irq_end = st.irq_end;
  assign rx_masked = st.masked;
  assign test_open = tg_open;
  assign test_clear = tg_clear;

  // ==========================================================
  // Checks
  sequence s_cmd(logic [7:0] c);
    clk_en && st.strobe && st.code == c;
  endsequence

  property p_default;
    @(posedge clk) disable iff (reset) s_cmd(CMD_SET_DEFAULT)
      |=> action_pulse[A_DEFAULT] && !cmd_chainable && !cmd_irq_end;
  endproperty
  a_default: assert property (p_default) else $error("set default not taken");

  property p_clear_off;
    @(posedge clk) disable iff (reset)
      s_cmd(CMD_CLEAR_A) and !st.ctrl[CTRL_CHIP_ON] |=> !action_pulse[A_CLEAR];
  endproperty
  a_clear_off: assert property (p_clear_off) else $error("clear accepted while off");

  property p_tx;
    @(posedge clk) disable iff (reset)
      s_cmd(CMD_TX_CRC) |=> action_pulse[A_TX_CRC] == $past(st.ctrl[0] & st.ctrl[1]);
  endproperty
  a_tx: assert property (p_tx) else $error("tx crc gating wrong");

  property p_reqa;
    @(posedge clk) disable iff (reset)
      s_cmd(CMD_TX_REQA) and !st.ctrl[CTRL_MODE_14A] |=> !action_pulse[A_TX_REQA];
  endproperty
  a_reqa: assert property (p_reqa) else $error("reqa outside 14443A");

  property p_field;
    @(posedge clk) disable iff (reset)
      s_cmd(CMD_FIELD_RESP) and st.ctrl[CTRL_CHIP_ON] |=> cmd_irq_end && cmd_chainable;
  endproperty
  a_field: assert property (p_field) else $error("field on attrs wrong");

  property p_unmask;
    @(posedge clk) disable iff (reset)
      action_pulse[A_UNMASK_RX] |-> !rx_masked;
  endproperty
  a_unmask: assert property (p_unmask) else $error("unmask ignored");

  property p_meas;
    @(posedge clk) disable iff (reset) action_pulse[A_MEAS_AMPL] |-> cmd_irq_end && !cmd_chainable;
  endproperty
  a_meas: assert property (p_meas) else $error("measure attrs wrong");

  property p_ctrl_kept;
    @(posedge clk) disable iff (reset)
      action_pulse[A_DEFAULT] |-> st.ctrl == $past(st.ctrl, 1);
  endproperty
  a_ctrl_kept: assert property (p_ctrl_kept) else $error("control changed by default");

  property p_unused;
    @(posedge clk) disable iff (reset)
      s_cmd(8'hD2) |=> action_pulse == '0 && $stable(rx_masked);
  endproperty
  a_unused: assert property (p_unused) else $error("unused code acted");

  property p_test;
    @(posedge clk) disable iff (reset)
      s_cmd(CMD_CLR_TEST) and st.last_code == CMD_TEST_ACCESS |=> test_clear;
  endproperty
  a_test: assert property (p_test) else $error("FCFA did not clear");

  property p_test_lone;
    @(posedge clk) disable iff (reset)
      s_cmd(CMD_CLR_TEST) and st.last_code != CMD_TEST_ACCESS |=> !test_clear;
  endproperty
  a_test_lone: assert property (p_test_lone) else $error("lone clear test acted");

  property p_clear_b;
    @(posedge clk) disable iff (reset)
      s_cmd(CMD_CLEAR_B) and st.ctrl[CTRL_CHIP_ON] |=> action_pulse[A_CLEAR] && cmd_chainable;
  endproperty
  a_clear_b: assert property (p_clear_b) else $error("second clear code not taken");

  property p_tx_nocrc;
    @(posedge clk) disable iff (reset) s_cmd(CMD_TX_NOCRC)
      |=> action_pulse[A_TX_NOCRC] == ($past(st.ctrl[CTRL_CHIP_ON]) && $past(st.ctrl[CTRL_TX_ON]));
  endproperty
  a_tx_nocrc: assert property (p_tx_nocrc) else $error("tx plain gating wrong");

  property p_wupa;
    @(posedge clk) disable iff (reset) s_cmd(CMD_TX_WUPA) and st.ctrl[CTRL_CHIP_ON] &&
      st.ctrl[CTRL_TX_ON] && st.ctrl[CTRL_MODE_14A] |=> action_pulse[A_TX_WUPA] && !cmd_irq_end;
  endproperty
  a_wupa: assert property (p_wupa) else $error("wakeup frame not sent");

  property p_field_init;
    @(posedge clk) disable iff (reset)
      s_cmd(CMD_FIELD_INIT) |=> action_pulse[A_FIELD_INIT] == $past(st.ctrl[CTRL_CHIP_ON]);
  endproperty
  a_field_init: assert property (p_field_init) else $error("initial field gating wrong");

  property p_go_normal;
    @(posedge clk) disable iff (reset) s_cmd(CMD_GO_NORMAL) and st.ctrl[CTRL_DETECT]
      |=> action_pulse[A_GO_NORMAL] && !st.ctrl[CTRL_DETECT];
  endproperty
  a_go_normal: assert property (p_go_normal) else $error("detection mode not left");

  property p_preset;
    @(posedge clk) disable iff (reset)
      s_cmd(CMD_ANALOG_PRESET) |=> action_pulse[A_PRESET] && cmd_chainable && !cmd_irq_end;
  endproperty
  a_preset: assert property (p_preset) else $error("preset not taken");

  property p_mask;
    @(posedge clk) disable iff (reset) s_cmd(CMD_MASK_RX) and st.ctrl[CTRL_CHIP_ON] &&
      st.ctrl[CTRL_RX_ON] |=> action_pulse[A_MASK_RX] && rx_masked;
  endproperty
  a_mask: assert property (p_mask) else $error("receive not masked");

  property p_squelch;
    @(posedge clk) disable iff (reset) s_cmd(CMD_SQUELCH)
      |=> action_pulse[A_SQUELCH] == ($past(st.ctrl[CTRL_CHIP_ON]) && $past(st.ctrl[CTRL_RX_ON]));
  endproperty
  a_squelch: assert property (p_squelch) else $error("squelch gating wrong");

  property p_gain;
    @(posedge clk) disable iff (reset)
      action_pulse[A_RESET_GAIN] |-> !cmd_chainable && !cmd_irq_end;
  endproperty
  a_gain: assert property (p_gain) else $error("gain reload attrs wrong");

  property p_regs;
    @(posedge clk) disable iff (reset)
      action_pulse[A_ADJ_REG] |-> cmd_irq_end && !cmd_chainable;
  endproperty
  a_regs: assert property (p_regs) else $error("regulator attrs wrong");

  property p_mod;
    @(posedge clk) disable iff (reset)
      action_pulse[A_CAL_MOD] |-> cmd_irq_end && !cmd_chainable;
  endproperty
  a_mod: assert property (p_mod) else $error("modulation attrs wrong");

  property p_ant;
    @(posedge clk) disable iff (reset)
      action_pulse[A_CAL_ANT] |-> cmd_irq_end && !cmd_chainable;
  endproperty
  a_ant: assert property (p_ant) else $error("antenna attrs wrong");

  property p_phase;
    @(posedge clk) disable iff (reset)
      action_pulse[A_MEAS_PHASE] |-> cmd_irq_end;
  endproperty
  a_phase: assert property (p_phase) else $error("phase attrs wrong");

  property p_rssi;
    @(posedge clk) disable iff (reset)
      s_cmd(CMD_CLEAR_RSSI) |=> action_pulse[A_CLEAR_RSSI] == $past(st.ctrl[CTRL_CHIP_ON]);
  endproperty
  a_rssi: assert property (p_rssi) else $error("signal strength clear gating wrong");

  property p_cap;
    @(posedge clk) disable iff (reset) s_cmd(CMD_CAL_CAP) or s_cmd(CMD_MEAS_CAP)
      |=> (action_pulse[A_CAL_CAP] || action_pulse[A_MEAS_CAP]) && cmd_irq_end && !cmd_chainable;
  endproperty
  a_cap: assert property (p_cap) else $error("capacitive sensor attrs wrong");

  property p_supply;
    @(posedge clk) disable iff (reset)
      s_cmd(CMD_MEAS_SUPPLY) |=> action_pulse[A_MEAS_SUPPLY] == $past(st.ctrl[CTRL_CHIP_ON]);
  endproperty
  a_supply: assert property (p_supply) else $error("supply measure gating wrong");
endmodule // dcd_decoder

// ==== hdl/dcd_pkg.sv ====
package dcd_pkg;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_SET_DEFAULT = 8'hC1;
  localparam logic [7:0] CMD_CLEAR_A = 8'hC2;
  localparam logic [7:0] CMD_CLEAR_B = 8'hC3;
  localparam logic [7:0] CMD_TX_CRC = 8'hC4;
  localparam logic [7:0] CMD_TX_NOCRC = 8'hC5;
  localparam logic [7:0] CMD_TX_REQA = 8'hC6;
  localparam logic [7:0] CMD_TX_WUPA = 8'hC7;
  localparam logic [7:0] CMD_FIELD_INIT = 8'hC8;
  localparam logic [7:0] CMD_FIELD_RESP = 8'hC9;
  localparam logic [7:0] CMD_FIELD_RESP0 = 8'hCA;
  localparam logic [7:0] CMD_GO_NORMAL = 8'hCB;
  localparam logic [7:0] CMD_ANALOG_PRESET = 8'hCC;
  localparam logic [7:0] CMD_MASK_RX = 8'hD0;
  localparam logic [7:0] CMD_UNMASK_RX = 8'hD1;
  localparam logic [7:0] CMD_MEAS_AMPL = 8'hD3;
  localparam logic [7:0] CMD_SQUELCH = 8'hD4;
  localparam logic [7:0] CMD_RESET_GAIN = 8'hD5;
  localparam logic [7:0] CMD_ADJ_REG = 8'hD6;
  localparam logic [7:0] CMD_CAL_MOD = 8'hD7;
  localparam logic [7:0] CMD_CAL_ANT = 8'hD8;
  localparam logic [7:0] CMD_MEAS_PHASE = 8'hD9;
  localparam logic [7:0] CMD_CLEAR_RSSI = 8'hDA;
  localparam logic [7:0] CMD_CAL_CAP = 8'hDD;
  localparam logic [7:0] CMD_MEAS_CAP = 8'hDE;
  localparam logic [7:0] CMD_MEAS_SUPPLY = 8'hDF;
  localparam logic [7:0] CMD_CLR_TEST = 8'hFA;
  localparam logic [7:0] CMD_TEST_ACCESS = 8'hFC;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_ACTION = 4'hC;
  // ==========================================================
  // Control field positions and reset value
  localparam int CTRL_CHIP_ON = 0;
  localparam int CTRL_TX_ON = 1;
  localparam int CTRL_RX_ON = 2;
  localparam int CTRL_MODE_14A = 3;
  localparam int CTRL_DETECT = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  // ==========================================================
  // Action pulse indices
  localparam int ACT_W = 24;
  localparam int A_DEFAULT = 0;
  localparam int A_CLEAR = 1;
  localparam int A_TX_CRC = 2;
  localparam int A_TX_NOCRC = 3;
  localparam int A_TX_REQA = 4;
  localparam int A_TX_WUPA = 5;
  localparam int A_FIELD_INIT = 6;
  localparam int A_FIELD_RESP = 7;
  localparam int A_FIELD_RESP0 = 8;
  localparam int A_GO_NORMAL = 9;
  localparam int A_PRESET = 10;
  localparam int A_MASK_RX = 11;
  localparam int A_UNMASK_RX = 12;
  localparam int A_MEAS_AMPL = 13;
  localparam int A_SQUELCH = 14;
  localparam int A_RESET_GAIN = 15;
  localparam int A_ADJ_REG = 16;
  localparam int A_CAL_MOD = 17;
  localparam int A_CAL_ANT = 18;
  localparam int A_MEAS_PHASE = 19;
  localparam int A_CLEAR_RSSI = 20;
  localparam int A_CAL_CAP = 21;
  localparam int A_MEAS_CAP = 22;
  localparam int A_MEAS_SUPPLY = 23;
  // ==========================================================
  // Decoded command attributes
  typedef struct packed {
    logic valid;
    logic need_chip;
    logic need_tx;
    logic need_rx;
    logic need_14a;
    logic need_detect;
    logic chainable;
    logic irq_end;
    logic [4:0] action;
  } dcd_attr_t;
endpackage

// ==== hdl/dcd_table.sv ====
`timescale 1ns/100ps
// ==========================================================
// Code-to-attribute lookup
module dcd_table
  import dcd_pkg::*;
(
  // Code in
  input wire logic [7:0] code,
  // Attributes out
  output dcd_pkg::dcd_attr_t attr
);
  function automatic dcd_attr_t mk(input int c, input int t, input int r, input int a,
                                   input int d, input int ch, input int ir, input int act);
    dcd_attr_t x;
    x = '{1'b1, 1'(c), 1'(t), 1'(r), 1'(a), 1'(d), 1'(ch), 1'(ir), 5'(act)};
    return x;
  endfunction

  always_comb begin
    attr = '0;
    case (code)
      CMD_SET_DEFAULT: attr = mk(0, 0, 0, 0, 0, 0, 0, A_DEFAULT);
      CMD_CLEAR_A, CMD_CLEAR_B: attr = mk(1, 0, 0, 0, 0, 1, 0, A_CLEAR);
      CMD_TX_CRC: attr = mk(1, 1, 0, 0, 0, 1, 0, A_TX_CRC);
      CMD_TX_NOCRC: attr = mk(1, 1, 0, 0, 0, 1, 0, A_TX_NOCRC);
      CMD_TX_REQA: attr = mk(1, 1, 0, 1, 0, 1, 0, A_TX_REQA);
      CMD_TX_WUPA: attr = mk(1, 1, 0, 1, 0, 1, 0, A_TX_WUPA);
      CMD_FIELD_INIT: attr = mk(1, 0, 0, 0, 0, 1, 1, A_FIELD_INIT);
      CMD_FIELD_RESP: attr = mk(1, 0, 0, 0, 0, 1, 1, A_FIELD_RESP);
      CMD_FIELD_RESP0: attr = mk(1, 0, 0, 0, 0, 1, 1, A_FIELD_RESP0);
      CMD_GO_NORMAL: attr = mk(0, 0, 0, 0, 1, 1, 0, A_GO_NORMAL);
      CMD_ANALOG_PRESET: attr = mk(0, 0, 0, 0, 0, 1, 0, A_PRESET);
      CMD_MASK_RX: attr = mk(1, 0, 1, 0, 0, 1, 0, A_MASK_RX);
      CMD_UNMASK_RX: attr = mk(1, 0, 1, 0, 0, 1, 0, A_UNMASK_RX);
      CMD_MEAS_AMPL: attr = mk(1, 0, 0, 0, 0, 0, 1, A_MEAS_AMPL);
      CMD_SQUELCH: attr = mk(1, 0, 1, 0, 0, 0, 0, A_SQUELCH);
      CMD_RESET_GAIN: attr = mk(1, 0, 0, 0, 0, 0, 0, A_RESET_GAIN);
      CMD_ADJ_REG: attr = mk(1, 0, 0, 0, 0, 0, 1, A_ADJ_REG);
      CMD_CAL_MOD: attr = mk(1, 0, 0, 0, 0, 0, 1, A_CAL_MOD);
      CMD_CAL_ANT: attr = mk(1, 0, 0, 0, 0, 0, 1, A_CAL_ANT);
      CMD_MEAS_PHASE: attr = mk(1, 0, 0, 0, 0, 0, 1, A_MEAS_PHASE);
      CMD_CLEAR_RSSI: attr = mk(1, 0, 0, 0, 0, 1, 0, A_CLEAR_RSSI);
      CMD_CAL_CAP: attr = mk(0, 0, 0, 0, 0, 0, 1, A_CAL_CAP);
      CMD_MEAS_CAP: attr = mk(0, 0, 0, 0, 0, 0, 1, A_MEAS_CAP);
      CMD_MEAS_SUPPLY: attr = mk(1, 0, 0, 0, 0, 0, 1, A_MEAS_SUPPLY);
      default: attr = '0;
    endcase
  end
endmodule // dcd_table

// ==== hdl/dcd_test_gate.sv ====
`timescale 1ns/100ps
// ==========================================================
// Test register access gate: FC opens, FC then FA clears
module dcd_test_gate
  import dcd_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Command stream
  input wire logic cmd_strobe,
  input wire logic [7:0] cmd_code,
  input wire logic soft_default,
  // Results
  output logic test_open,
  output logic test_clear
);
  typedef struct packed {
    logic open;
    logic last_fc;
    logic clr;
  } dcd_tg_t;
  dcd_tg_t st, next_st;

  always_comb begin
    next_st = st;
    next_st.clr = 1'b0;
    if (soft_default) begin
      next_st = '0;
    end else if (cmd_strobe) begin
      if (cmd_code == CMD_TEST_ACCESS) begin
        next_st.open = 1'b1;
      end
      if (cmd_code == CMD_CLR_TEST && st.last_fc) begin
        next_st.clr = 1'b1;
      end
      next_st.last_fc = (cmd_code == CMD_TEST_ACCESS);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign test_open = st.open;
  assign test_clear = st.clr;
endmodule // dcd_test_gate
